// ===== hdl/cxp_stream_status_monitor.sv
// frame size guard and stream status event queue
// How it works
// - pixels beyond header width times height are discarded
// - short frames are padded with filler up to header size
// - any size mismatch raises an event with the size flag
// - each record is four 16-bit words read at word0..word3
// - word0 holds the image tag of the frame concerned
// - word1 holds stream id high byte, low byte reads zero
// - word2 bits 0..3 crc, marker, uncorrectable, size; rest zero
// - word3 bit0 is 0 for damaged, 1 for dropped frame
// - frame with a bad header is dropped whole, dropped event
// - frame starting during padding is dropped with a dropped event
// - gap in frame tags raises a dropped event
// - damaged event lost to full queue sets word3 bit1 later
// - lost dropped events set word3 bit2 and count in bits 3..15
// - counter wraps yet bit2 stays set, zero count means overflow
// - every record queued gives a one-cycle interrupt pulse
// - same-tag same-type events merge into the tail record unless the tail is the head
// - a record carrying loss information never takes a merge
// - crc errors take the tag of the frame current at packet end
//
// Chosen here: the plain strobed port and the register offsets.
`default_nettype none
`include "stream_status_map.svh"

module cxp_stream_status_monitor #(
  parameter int QDEPTH = 8,
  parameter int QW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // rebuilt stream from the depacketizer
  input wire stream_status_pkg::pix_in_s in_beat,
  input wire stream_status_pkg::hdr_s in_hdr,
  input wire logic crc_err,
  // stream toward the pixel pipeline
  output stream_status_pkg::pix_out_s out_beat,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // event notification
  output logic event_irq
);

  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + 16'h0001;
  endfunction : inc16

  stream_status_pkg::fsm_e state;
  stream_status_pkg::fsm_e next_state;
  logic [15:0] x, y, width, height, cur_tag, prev_tag;
  logic [7:0] cur_stream;
  logic frame_full, over, drop_pend, have_prev, enable;

  logic beat, sof, eof, hdr_bad, accept, in_pass, full_e, over_e, emit, lastpx;
  logic line_end, surplus, end_pass, short_frame, mismatch, gap, sof_lost, pad_done;
  logic next_full, next_drop_pend;
  logic [15:0] w_e, h_e, x_e, y_e, exp_tag, cur_tag_e, next_x, next_y;
  logic [7:0] cur_stream_e;

  assign beat = in_beat.valid;
  assign sof = beat & in_beat.sof;
  assign eof = beat & in_beat.eof;
  assign hdr_bad = in_hdr.marker_err | in_hdr.uncorr_err;
  assign accept = (state == stream_status_pkg::st_idle) & sof & ~hdr_bad;
  assign w_e = accept ? in_hdr.width : width;
  assign h_e = accept ? in_hdr.height : height;
  assign x_e = accept ? 16'h0000 : x;
  assign y_e = accept ? 16'h0000 : y;
  assign full_e = accept ? 1'b0 : frame_full;
  assign over_e = accept ? 1'b0 : over;
  assign cur_tag_e = accept ? in_hdr.tag : cur_tag;
  assign cur_stream_e = accept ? in_hdr.stream : cur_stream;
  assign in_pass = (state == stream_status_pkg::st_pass) | accept;
  assign line_end = (x_e == w_e - 16'h0001);
  assign lastpx = line_end & (y_e == h_e - 16'h0001);

  // emit only up to the header size
  assign emit = (in_pass & beat & ~full_e) | ((state == stream_status_pkg::st_pad) & ~frame_full);
  assign surplus = in_pass & beat & full_e;
  assign end_pass = in_pass & eof;
  assign short_frame = ~full_e & ~(emit & lastpx);
  // size mismatch found at frame end
  assign mismatch = end_pass & (short_frame | over_e | surplus);
  assign pad_done = (state == stream_status_pkg::st_pad) & emit & lastpx;
  assign next_full = (emit & lastpx) | full_e;
  assign next_x = ~emit ? x : (line_end ? 16'h0000 : inc16(x_e));
  assign next_y = ~emit ? y : (line_end ? inc16(y_e) : y_e);
  // a frame that begins while padding is swallowed to its end
  assign next_drop_pend = (state == stream_status_pkg::st_pad) ? ((drop_pend | sof) & ~eof) : 1'b0;
  // tag gap detection against the last seen start
  assign exp_tag = inc16(prev_tag);
  assign gap = sof & have_prev & (in_hdr.tag != exp_tag);
  assign sof_lost = sof & ~accept;

  always_comb
  begin
    next_state = state;
    case (state)
      stream_status_pkg::st_idle:
      begin
        if (sof && hdr_bad)
          next_state = eof ? stream_status_pkg::st_idle : stream_status_pkg::st_drop;
        else if (sof && eof)
          next_state = short_frame ? stream_status_pkg::st_pad : stream_status_pkg::st_idle;
        else if (sof)
          next_state = stream_status_pkg::st_pass;
      end
      stream_status_pkg::st_pass:
      begin
        if (eof)
          next_state = short_frame ? stream_status_pkg::st_pad : stream_status_pkg::st_idle;
      end
      stream_status_pkg::st_pad:
      begin
        // keep filling until the header size is reached
        if (pad_done)
          next_state = next_drop_pend ? stream_status_pkg::st_drop : stream_status_pkg::st_idle;
      end
      stream_status_pkg::st_drop:
      begin
        if (eof)
          next_state = stream_status_pkg::st_idle;
      end
      default: next_state = stream_status_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= stream_status_pkg::st_idle;
      x <= 16'h0000;
      y <= 16'h0000;
      width <= 16'h0000;
      height <= 16'h0000;
      cur_tag <= 16'h0000;
      cur_stream <= 8'h00;
      prev_tag <= 16'h0000;
      have_prev <= 1'b0;
      frame_full <= 1'b0;
      over <= 1'b0;
      drop_pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      x <= next_x;
      y <= next_y;
      width <= w_e;
      height <= h_e;
      cur_tag <= cur_tag_e;
      cur_stream <= cur_stream_e;
      frame_full <= next_full;
      over <= over_e | surplus;
      drop_pend <= next_drop_pend;
      if (sof)
      begin
        prev_tag <= in_hdr.tag;
        have_prev <= 1'b1;
      end
    end
  end

  // registered outbound stream; filler is a constant since its value is free
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      out_beat <= '0;
    else
    begin
      out_beat.valid <= emit;
      out_beat.sol <= emit & (x_e == 16'h0000);
      out_beat.eol <= emit & line_end;
      out_beat.eof <= emit & lastpx;
      out_beat.pad <= emit & (state == stream_status_pkg::st_pad);
      out_beat.data <= (state == stream_status_pkg::st_pad) ? `PAD_DATA : in_beat.data;
    end
  end

  // event candidate, at most one per cycle
  stream_status_pkg::ev_cand_s cand;
  logic cand_lost, cand_valid;
  logic [3:0] cand_flags;

  // bad header or any unaccepted start means a dropped frame
  assign cand_lost = sof_lost | gap;
  assign cand_valid = enable & (cand_lost | mismatch | crc_err);
  // crc pulse takes whatever frame is current at packet end
  assign cand_flags[`W2_CRC_BIT] = crc_err;
  assign cand_flags[`W2_MARKER_BIT] = sof_lost & in_hdr.marker_err;
  assign cand_flags[`W2_UNCORR_BIT] = sof_lost & in_hdr.uncorr_err;
  assign cand_flags[`W2_SIZE_BIT] = mismatch;
  // tag: first missing tag on a gap, else the frame concerned
  assign cand.tag = gap ? exp_tag : (sof_lost ? in_hdr.tag : cur_tag_e);
  assign cand.stream = cand_lost ? in_hdr.stream : cur_stream_e;
  assign cand.flags = cand_flags;
  assign cand.lost = cand_lost;

  // event queue
  stream_status_pkg::ev_rec_s mem [QDEPTH];
  stream_status_pkg::ev_rec_s new_rec, rec_last, head_rec;
  logic [QDEPTH-1:0] locked;
  logic [QW-1:0] head, tail, last;
  logic [QW:0] count;
  logic lcorr, llost, pop, merge_ok, not_full, push, fail;
  logic [12:0] lcnt;

  assign last = tail - QW'(1);
  assign rec_last = mem[last];
  assign head_rec = mem[head];
  assign pop = reg_wr & (reg_addr == `REG_POP) & (count != '0);
  // merge only into a tail that the host is not reading
  // never merge while loss information is pending or stored
  assign merge_ok = cand_valid & ~lcorr & ~llost & ~locked[last] &
    (count > (QW+1)'({pop, ~pop})) &
    (rec_last.ev.tag == cand.tag) & (rec_last.ev.lost == cand.lost);
  // full queue, unless the head leaves this cycle
  assign not_full = (count != (QW+1)'(QDEPTH)) | pop;
  assign push = cand_valid & ~merge_ok & not_full;
  assign fail = cand_valid & ~merge_ok & ~not_full;
  assign new_rec.ev = cand;
  assign new_rec.loss = {llost, lcorr};
  assign new_rec.lost_cnt = lcnt;

  // payload storage needs no reset; it is read only below count
  always_ff @(posedge clk)
  begin
    if (push)
      mem[tail] <= new_rec;
    else if (merge_ok)
      mem[last].ev.flags <= rec_last.ev.flags | cand.flags;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      head <= '0;
      tail <= '0;
      count <= '0;
      locked <= '0;
      lcorr <= 1'b0;
      llost <= 1'b0;
      lcnt <= 13'h0000;
      event_irq <= 1'b0;
    end
    else
    begin
      event_irq <= push;
      if (push)
      begin
        tail <= tail + QW'(1);
        locked[tail] <= lcorr | llost;
      end
      if (pop)
        head <= head + QW'(1);
      if (push && !pop)
        count <= count + {{QW{1'b0}}, 1'b1};
      else if (pop && !push)
        count <= count - {{QW{1'b0}}, 1'b1};
      if (fail && !cand.lost)
        lcorr <= 1'b1;
      else if (push)
        lcorr <= 1'b0;
      // dropped event loss flag and counter
      if (fail && cand.lost)
      begin
        llost <= 1'b1;
        lcnt <= lcnt + 13'h0001;
      end
      else if (push)
      begin
        llost <= 1'b0;
        lcnt <= 13'h0000;
      end
    end
  end

  // register read mux
  logic hv;
  logic [15:0] word0, word1, word2, word3, status_word, rd_mux;

  assign hv = (count != '0);
  // head record exposed as four words, zero when empty
  assign word0 = hv ? head_rec.ev.tag : 16'h0000;
  assign word1 = hv ? {head_rec.ev.stream, 8'h00} : 16'h0000;
  assign word2 = hv ? {12'h000, head_rec.ev.flags} : 16'h0000;
  assign word3 = hv ? {head_rec.lost_cnt, head_rec.loss, head_rec.ev.lost} : 16'h0000;
  assign status_word = {2'h0, llost, lcorr, state, 8'(count)};
  assign rd_mux = (reg_addr == `REG_CTRL) ? {15'h0000, enable} :
    (reg_addr == `REG_STATUS) ? status_word :
    (reg_addr == `REG_WORD0) ? word0 :
    (reg_addr == `REG_WORD1) ? word1 :
    (reg_addr == `REG_WORD2) ? word2 :
    (reg_addr == `REG_WORD3) ? word3 : 16'h0000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enable <= `CTRL_RESET;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      if (reg_wr && (reg_addr == `REG_CTRL))
        enable <= reg_wdata[`CTRL_ENABLE_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_no_surplus_out: assert property (
    frame_full && (state == stream_status_pkg::st_pass) |-> !emit)
    else $error("pixel passed beyond header size");
  chk_pad_fills: assert property (
    (state == stream_status_pkg::st_pad) && !frame_full |=> out_beat.valid && out_beat.pad)
    else $error("padding did not emit filler");
  chk_size_event: assert property (
    mismatch && enable |-> cand_valid && cand.flags[`W2_SIZE_BIT])
    else $error("size mismatch without event");
  chk_word0_tag: assert property (
    reg_rd && (reg_addr == `REG_WORD0) && hv |=> reg_rdata == $past(head_rec.ev.tag))
    else $error("word0 not the head tag");
  chk_word1_low: assert property (
    reg_rd && (reg_addr == `REG_WORD1) |=> reg_rdata[7:0] == 8'h00)
    else $error("word1 reserved byte not zero");
  chk_word2_high: assert property (
    reg_rd && (reg_addr == `REG_WORD2) |=> reg_rdata[15:4] == 12'h000)
    else $error("word2 reserved bits not zero");
  chk_drop_type: assert property (
    sof && !accept && enable |-> cand_valid && cand.lost)
    else $error("dropped frame not typed as lost");
  chk_gap_tag: assert property (
    gap && enable |-> cand.lost && (cand.tag == exp_tag))
    else $error("tag gap not reported");
  chk_irq_push: assert property (
    push |=> event_irq ##1 (!event_irq || $past(push)))
    else $error("queued record without single pulse");
  chk_corr_loss: assert property (
    fail && !cand.lost |=> lcorr)
    else $error("damaged event loss not flagged");
  chk_lost_count: assert property (
    fail && cand.lost |=> llost && (lcnt == $past(lcnt) + 13'h0001))
    else $error("lost event count not advanced");
  chk_loss_lock: assert property (
    push && (lcorr || llost) |=> locked[$past(tail)] && !lcorr && !llost)
    else $error("loss record not locked");

  cov_pad_frame: cover property ((state == stream_status_pkg::st_pad) ##1 pad_done);
  cov_drop_in_pad: cover property ((state == stream_status_pkg::st_pad) && sof);
  cov_queue_fail: cover property (fail ##[1:50] push);
  cov_merge: cover property (merge_ok);

endmodule : cxp_stream_status_monitor

`default_nettype wire

// ===== hdl/stream_status_map.svh
// register offsets, word field positions and reset values of the stream status monitor
`ifndef STREAM_STATUS_MAP_SVH
`define STREAM_STATUS_MAP_SVH

// register word addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_WORD0 8'h02
`define REG_WORD1 8'h03
`define REG_WORD2 8'h04
`define REG_WORD3 8'h05
`define REG_POP 8'h06

// control fields and reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1

// word 2 error flags
`define W2_CRC_BIT 0
`define W2_MARKER_BIT 1
`define W2_UNCORR_BIT 2
`define W2_SIZE_BIT 3

// word 3 layout
`define W3_TYPE_BIT 0
`define W3_CORR_LOSS_BIT 1
`define W3_LOST_LOSS_BIT 2
`define W3_CNT_LSB 3

// filler pixel value used while padding
`define PAD_DATA 16'h0000

`endif

// ===== hdl/stream_status_pkg.sv
// types shared by the stream status monitor
`default_nettype none

package stream_status_pkg;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [15:0] data;
  } pix_in_s;

  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] tag;
    logic [7:0] stream;
    logic marker_err;
    logic uncorr_err;
  } hdr_s;

  typedef struct packed {
    logic valid;
    logic sol;
    logic eol;
    logic eof;
    logic pad;
    logic [15:0] data;
  } pix_out_s;

  typedef struct packed {
    logic [15:0] tag;
    logic [7:0] stream;
    logic [3:0] flags;
    logic lost;
  } ev_cand_s;

  typedef struct packed {
    ev_cand_s ev;
    logic [1:0] loss;
    logic [12:0] lost_cnt;
  } ev_rec_s;

  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_pass = 4'h2,
    st_pad = 4'h4,
    st_drop = 4'h8
  } fsm_e;

endpackage : stream_status_pkg

`default_nettype wire

// ===== sim/camera_model.sv
// camera side model that feeds rebuilt frames into the monitor
`default_nettype none

module camera_model #(
  parameter logic [7:0] STREAM_ID = 8'h3c
) (
  // clock
  input wire logic clk,
  // rebuilt stream toward the monitor
  output stream_status_pkg::pix_in_s in_beat,
  output stream_status_pkg::hdr_s in_hdr,
  output logic crc_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    in_beat = '0;
    in_hdr = '0;
    crc_err = 1'b0;
  end

  // header only counts on sof, so it is scrambled on every other beat
  task automatic send(input logic [15:0] tag, input int w, input int h, input int n,
                      input logic [1:0] herr, input int crc_at);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      in_beat.valid <= 1'b1;
      in_beat.sof <= (i == 0);
      in_beat.eof <= (i == n - 1);
      in_beat.data <= 16'(i + 1);
      in_hdr <= (i == 0) ? {16'(w), 16'(h), tag, STREAM_ID, herr} : ~in_hdr;
      crc_err <= (i == crc_at);
    end
    @(posedge clk);
    in_beat.valid <= 1'b0;
    in_beat.sof <= 1'b0;
    in_beat.eof <= 1'b0;
    in_beat.data <= ~in_beat.data;
    in_hdr <= ~in_hdr;
    crc_err <= 1'b0;
  endtask : send
endmodule : camera_model

`default_nettype wire

// ===== sim/cxp_stream_status_monitor_test.sv
// self-checking bench of the stream status monitor
`default_nettype none
`include "stream_status_map.svh"

module cxp_stream_status_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SID = 8'h3c;
  logic clk;
  logic arst_n;
  stream_status_pkg::pix_in_s in_beat;
  stream_status_pkg::hdr_s in_hdr;
  logic crc_err;
  stream_status_pkg::pix_out_s out_beat;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic event_irq;
  int n_mismatch = 0;
  int check_count = 0;
  int n_out = 0;
  int n_pad = 0;
  int n_irq = 0;
  int n_rec = 0;
  int n_sol = 0;
  int n_eol = 0;
  int n_eof = 0;
  int n_sum = 0;
  logic [15:0] tag = 16'h0001;
  logic [15:0] rd;

  // shallow queue so that loss is reached quickly
  cxp_stream_status_monitor #(.QDEPTH(2), .QW(1)) cxp_stream_status_monitor_i (
    .clk(clk), .arst_n(arst_n), .in_beat(in_beat), .in_hdr(in_hdr), .crc_err(crc_err),
    .out_beat(out_beat), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_irq(event_irq));

  camera_model #(.STREAM_ID(SID)) camera_model_i (
    .clk(clk), .in_beat(in_beat), .in_hdr(in_hdr), .crc_err(crc_err));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    n_out <= n_out + int'(out_beat.valid === 1'b1);
    n_pad <= n_pad + int'(out_beat.valid === 1'b1 && out_beat.pad === 1'b1);
    n_irq <= n_irq + int'(event_irq === 1'b1);
    n_sol <= n_sol + int'(out_beat.valid === 1'b1 && out_beat.sol === 1'b1);
    n_eol <= n_eol + int'(out_beat.valid === 1'b1 && out_beat.eol === 1'b1);
    n_eof <= n_eof + int'(out_beat.valid === 1'b1 && out_beat.eof === 1'b1);
    n_sum <= n_sum + ((out_beat.valid === 1'b1) ? int'(out_beat.data) : 0);
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // settle time covers the longest padding run of the header size
  task automatic frame(input int w, input int h, input int n, input logic [1:0] herr,
                       input int crc_at, input int exp_out, input int exp_pad);
    int b_out;
    int b_pad;
    int b_sol;
    int b_eol;
    int b_eof;
    int b_sum;
    int m;
    b_out = n_out;
    b_pad = n_pad;
    b_sol = n_sol;
    b_eol = n_eol;
    b_eof = n_eof;
    b_sum = n_sum;
    // passed beats carry 1..m, the rest of the raster is filler
    m = exp_out - exp_pad;
    camera_model_i.send(tag, w, h, n, herr, crc_at);
    tag++;
    repeat (w * h + 4) @(posedge clk);
    cmp(16'(n_out - b_out), 16'(exp_out));
    cmp(16'(n_pad - b_pad), 16'(exp_pad));
    cmp(16'(n_sol - b_sol), 16'(exp_out / w));
    cmp(16'(n_eol - b_eol), 16'(exp_out / w));
    cmp(16'(n_eof - b_eof), 16'(exp_out > 0));
    cmp(16'(n_sum - b_sum), 16'(m * (m + 1) / 2 + exp_pad * int'(`PAD_DATA)));
  endtask : frame

  task automatic rec(input logic [15:0] t, input logic [15:0] m2, input logic [15:0] w2,
                     input logic [15:0] w3);
    reg_read(`REG_WORD0, rd);
    cmp(rd, t);
    reg_read(`REG_WORD1, rd);
    cmp(rd & 16'hff00, {SID, 8'h00});
    reg_read(`REG_WORD2, rd);
    cmp(rd & m2, w2);
    reg_read(`REG_WORD3, rd);
    cmp(rd, w3);
    reg_write(`REG_POP, 16'h0000);
    n_rec++;
  endtask : rec

  // two records fill the queue, then a damaged event (only when corr is set) and nl dropped events are lost
  task automatic loss_run(input int nl, input logic corr);
    logic [15:0] t0;
    t0 = tag;
    frame(2, 2, 6, 2'b00, -1, 4, 0);
    frame(2, 2, 6, 2'b00, -1, 4, 0);
    if (corr)
      frame(2, 2, 6, 2'b00, -1, 4, 0);
    for (int k = 0; k < nl; k++)
      frame(1, 1, 1, 2'b10, -1, 0, 0);
    rec(t0, 16'h000f, 16'h0008, 16'h0000);
    frame(2, 2, 6, 2'b00, -1, 4, 0);
    rec(t0 + 16'h1, 16'h000f, 16'h0008, 16'h0000);
    rec(tag - 16'h1, 16'h000f, 16'h0008, {13'(nl), 1'b1, corr, 1'b0});
  endtask : loss_run

  initial
  begin
    // about 58k cycles of traffic are expected; give up at 75k
    #300000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    reg_read(`REG_CTRL, rd);
    cmp(rd, 16'h0001);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 16'h0100);
    reg_read(8'h7f, rd);
    cmp(rd, 16'h0000);
    frame(2, 2, 4, 2'b00, -1, 4, 0);
    frame(2, 2, 6, 2'b00, -1, 4, 0);
    frame(2, 2, 1, 2'b00, -1, 4, 3);
    rec(16'h0002, 16'h000f, 16'h0008, 16'h0000);
    rec(16'h0003, 16'h000f, 16'h0008, 16'h0000);
    camera_model_i.send(tag, 4, 4, 1, 2'b00, -1);
    tag++;
    frame(4, 4, 2, 2'b00, -1, 16, 15);
    rec(tag - 16'h2, 16'h000f, 16'h0008, 16'h0000);
    rec(tag - 16'h1, 16'h000f, 16'h0000, 16'h0001);
    for (int k = 0; k < 2; k++)
    begin
      frame(2, 2, 4, 2'b10 >> k, -1, 0, 0);
      rec(tag - 16'h1, 16'h000f, 16'h0002 << k, 16'h0001);
    end
    frame(2, 2, 4, 2'b00, 3, 4, 0);
    rec(tag - 16'h1, 16'h000f, 16'h0001, 16'h0000);
    tag = tag + 16'h2;
    frame(2, 2, 4, 2'b00, -1, 4, 0);
    // crc mid-frame, then surplus at the end: same tag, one record, one pulse
    frame(2, 2, 6, 2'b00, 1, 4, 0);
    rec(tag - 16'h4, 16'h000f, 16'h0000, 16'h0001);
    rec(tag - 16'h1, 16'h000f, 16'h0009, 16'h0000);
    reg_write(`REG_CTRL, 16'h0000);
    frame(2, 2, 6, 2'b00, -1, 4, 0);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 16'h0100);
    reg_write(`REG_CTRL, 16'h0001);
    loss_run(3, 1'b1);
    loss_run(8192, 1'b0);
    reg_read(`REG_STATUS, rd);
    cmp(rd, 16'h0100);
    cmp(16'(n_irq), 16'(n_rec));
    print_verdict();
  end
endmodule : cxp_stream_status_monitor_test

`default_nettype wire
